// >>> rtl/gpm_power_ctrl.sv
// What this block does
// - Clear charging after two good taper windows
// - On termination optionally copy full capacity over
// - Charging voltage register, default 4200 mV
// - Function code 1: line negated outside temperature
// - Release inhibit only inside hysteresis band
// - Codes 0/2: temperature sampled on query while charging
// - Normal mode measures and decides state changes
// - Light sleep when enabled and current low
// - Leave light sleep on traffic, current, wake
// - Sleep when enabled and current low
// - Offset calibration before entering sleep
// - Leave sleep on current rise or wake
// - Stretch SCL up to 4 ms in sleep
// - Battery removed: stop gauging, await insertion
// - Insertion: open circuit voltage, good line, profiles
// - Wake for host commands while awaiting insertion
// - Hibernate on low voltage with valid reading
// - Hibernate on request and low current
// - Only addressed I2C traffic ends hibernate
// - Good line negated throughout hibernate
// - After hibernate wake, reinitialize battery data
// - Count software resets, report on query
// - Function code from two select bits
// - Polarity bit sets good line level
//
// The address map and the APB register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module gpm_power_ctrl #(
   parameter int unsigned INIT_CYC    = gpm_pkg::INIT_CYC,
   parameter int unsigned STRETCH_CYC = gpm_pkg::STRETCH_CYC
) (
   input  wire logic               clk_i,
   input  wire logic               srst_i,
   input  wire logic               psel_i,
   input  wire logic               penable_i,
   input  wire logic               pwrite_i,
   input  wire logic [7:0]         paddr_i,
   input  wire logic [31:0]        pwdata_i,
   input  wire logic [3:0]         pstrb_i,
   output logic      [31:0]        prdata_o,
   output logic                    pready_o,
   output logic                    pslverr_o,
   input  wire logic               scl_i,
   input  wire logic               sda_i,
   output logic                    scl_o,
   output logic                    scl_oe_o,
   input  wire logic               bat_present_i,
   input  wire logic signed [15:0] mean_current_i,
   input  wire logic        [15:0] cell_voltage_i,
   input  wire logic signed [15:0] temperature_i,
   input  wire logic        [15:0] cap_delta_i,
   input  wire logic               meas_tick_i,
   input  wire logic               taper_tick_i,
   input  wire logic               wake_det_i,
   input  wire logic               ocv_done_i,
   input  wire logic               calib_done_i,
   output logic                    battery_good_line_o,
   output logic                    charging_o,
   output logic                    gauging_o,
   output logic                    hfo_on_o,
   output logic                    cpu_run_o,
   output logic                    ocv_measure_o,
   output logic                    profile_select_o,
   output logic                    calib_start_o,
   output logic                    temp_sample_o,
   output logic      [2:0]         power_mode_o
);
   gpm_pkg::gpm_state_t state_q;
   gpm_pkg::gpm_state_t state_d;
   logic [15:0] rf_q [0:15];
   logic [15:0] reset_cnt_q;
   logic [15:0] result_q;
   logic [15:0] acc_q;
   logic [15:0] acc_d;
   logic        ok_cnt_q;
   logic        charging_q;
   logic        inhibit_q;
   logic        good_q;
   logic        ocv_valid_q;
   logic        serve_q;
   logic [31:0] init_cnt_q;
   logic [31:0] stretch_q;
   logic        act_w;
   logic        hit_w;
   logic        stop_w;
   logic        wr_w;
   logic        rd_setup_w;
   logic [3:0]  idx_w;
   logic        term_w;
   logic        win_ok_w;
   logic        pfc1_w;
   logic        low_i_w;
   logic        high_i_w;
   logic        hib_w;
   logic        gauge_w;
   logic        sw_rst_w;

   function automatic logic [15:0] abs16(input logic signed [15:0] v);
      abs16 = v[15] ? 16'(-v) : v;
   endfunction

   function automatic logic [15:0] rst_val(input logic [3:0] i);
      case ({2'b00, i, 2'b00})
         gpm_pkg::A_CFG:  rst_val = gpm_pkg::RST_CFG;
         gpm_pkg::A_CHGV: rst_val = gpm_pkg::RST_CHGV;
         gpm_pkg::A_TAPI: rst_val = gpm_pkg::RST_TAPI;
         gpm_pkg::A_TAPV: rst_val = gpm_pkg::RST_TAPV;
         gpm_pkg::A_SLPI: rst_val = gpm_pkg::RST_SLPI;
         gpm_pkg::A_HIBI: rst_val = gpm_pkg::RST_HIBI;
         gpm_pkg::A_HIBV: rst_val = gpm_pkg::RST_HIBV;
         gpm_pkg::A_TLO:  rst_val = gpm_pkg::RST_TLO;
         gpm_pkg::A_THI:  rst_val = gpm_pkg::RST_THI;
         gpm_pkg::A_THYS: rst_val = gpm_pkg::RST_THYS;
         gpm_pkg::A_RCAP: rst_val = gpm_pkg::RST_RCAP;
         gpm_pkg::A_FCAP: rst_val = gpm_pkg::RST_FCAP;
         default:         rst_val = 16'h0000;
      endcase
   endfunction

   gpm_i2c_watch u_watch (
      .clk_i  (clk_i),
      .srst_i (srst_i),
      .scl_i  (scl_i),
      .sda_i  (sda_i),
      .act_o  (act_w),
      .hit_o  (hit_w),
      .stop_o (stop_w)
   );

   // Zero-wait slave: pready only in the access cycle
   assign idx_w      = paddr_i[5:2];
   assign wr_w       = psel_i & penable_i & pready_o & pwrite_i &
                       ~pslverr_o;
   assign rd_setup_w = psel_i & ~penable_i & ~pwrite_i;
   assign sw_rst_w   = wr_w && (paddr_i == gpm_pkg::A_CTRL) &&
                       (pwdata_i[15:0] == gpm_pkg::SUB_RESET);
   assign pfc1_w     = ~rf_q[0][gpm_pkg::B_FC_HI] &
                       rf_q[0][gpm_pkg::B_FC_LO];
   assign low_i_w    = abs16(mean_current_i) < rf_q[6];
   assign high_i_w   = abs16(mean_current_i) > rf_q[6];
   assign hib_w      = ocv_valid_q &&
      ((cell_voltage_i < rf_q[8]) ||
       (rf_q[0][gpm_pkg::B_HIBREQ] &&
        abs16(mean_current_i) < rf_q[7]));
   assign gauge_w    = state_q inside {gpm_pkg::GPM_NORMAL,
      gpm_pkg::GPM_LIGHT, gpm_pkg::GPM_CALIB, gpm_pkg::GPM_SLEEP};

   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h0000_0000;
      end
      else
      begin
         pready_o  <= psel_i & ~penable_i;
         pslverr_o <= psel_i & ~penable_i &
                      ((paddr_i[7:6] != 2'b00) | (paddr_i[1:0] != 2'b00));
         if (rd_setup_w)
            case (paddr_i)
               gpm_pkg::A_CTRL: prdata_o <= 32'h0000_0000;
               gpm_pkg::A_RES:  prdata_o <= {16'h0000, result_q};
               gpm_pkg::A_STAT: prdata_o <= {24'h00_0000, serve_q,
                  charging_q, inhibit_q, ocv_valid_q, good_q, state_q};
               gpm_pkg::A_TEMP: prdata_o <= {16'h0000, temperature_i};
               default:         prdata_o <= {16'h0000, rf_q[idx_w]};
            endcase
      end
   end

   // Hardware load of remaining capacity beats a software write
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         for (int i = 0; i < 16; i++)
            rf_q[i] <= rst_val(4'(i));
      end
      else
      begin
         if (wr_w && !(paddr_i inside {gpm_pkg::A_CTRL,
             gpm_pkg::A_RES, gpm_pkg::A_STAT, gpm_pkg::A_TEMP}))
         begin
            if (pstrb_i[0])
               rf_q[idx_w][7:0] <= pwdata_i[7:0];
            if (pstrb_i[1])
               rf_q[idx_w][15:8] <= pwdata_i[15:8];
         end
         if (term_w && rf_q[0][gpm_pkg::B_COPY])
            rf_q[13] <= rf_q[14];
         if (state_q == gpm_pkg::GPM_HIBERNATE && hit_w)
            rf_q[0][gpm_pkg::B_HIBREQ] <= 1'b0;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         reset_cnt_q <= 16'h0000;
         result_q    <= 16'h0000;
      end
      else if (wr_w && (paddr_i == gpm_pkg::A_CTRL))
      begin
         if (sw_rst_w)
            reset_cnt_q <= reset_cnt_q + 16'h0001;
         result_q <= (pwdata_i[15:0] == gpm_pkg::SUB_RESET_DATA) ?
                     reset_cnt_q : 16'h0000;
      end
   end

   // Charge termination over taper windows
   assign acc_d    = acc_q + (meas_tick_i ? cap_delta_i : 16'h0000);
   assign win_ok_w = (mean_current_i < $signed(rf_q[4])) &&
                     (acc_d > gpm_pkg::TAPER_UAH);
   assign term_w   = taper_tick_i && win_ok_w && ok_cnt_q && charging_q &&
      ({1'b0, cell_voltage_i} > {1'b0, rf_q[3]} - {1'b0, rf_q[5]});

   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         acc_q      <= 16'h0000;
         ok_cnt_q   <= 1'b0;
         charging_q <= 1'b0;
      end
      else
      begin
         acc_q <= taper_tick_i ? 16'h0000 : acc_d;
         if (taper_tick_i)
            ok_cnt_q <= win_ok_w & ~term_w;
         if (term_w)
            charging_q <= 1'b0;
         else if (mean_current_i > $signed(rf_q[4]))
            charging_q <= 1'b1;
      end
   end

   // Charge inhibit, judged at each temperature sample
   always_ff @(posedge clk_i)
   begin
      if (srst_i || !pfc1_w)
         inhibit_q <= 1'b0;
      else if (meas_tick_i && gauge_w)
      begin
         if (temperature_i < $signed(rf_q[9]) ||
             temperature_i > $signed(rf_q[10]))
            inhibit_q <= 1'b1;
         else if (temperature_i >= $signed(rf_q[9] + rf_q[11]) &&
                  temperature_i <= $signed(rf_q[10] - rf_q[11]))
            inhibit_q <= 1'b0;
      end
   end

   always_comb
   begin
      state_d = state_q;
      case (state_q)
         gpm_pkg::GPM_INSERT_WAIT:
            if (bat_present_i)
               state_d = gpm_pkg::GPM_INIT;
         gpm_pkg::GPM_INIT:
            if (ocv_done_i || init_cnt_q >= INIT_CYC - 1)
               state_d = gpm_pkg::GPM_NORMAL;
         gpm_pkg::GPM_NORMAL:
            if (hib_w)
               state_d = gpm_pkg::GPM_HIBERNATE;
            else if (rf_q[0][gpm_pkg::B_LSLP] && low_i_w)
               state_d = gpm_pkg::GPM_LIGHT;
            else if (rf_q[0][gpm_pkg::B_SLEEP] && low_i_w)
               state_d = gpm_pkg::GPM_CALIB;
         gpm_pkg::GPM_LIGHT:
            if (act_w || high_i_w || wake_det_i)
               state_d = gpm_pkg::GPM_NORMAL;
         gpm_pkg::GPM_CALIB:
            if (high_i_w || wake_det_i)
               state_d = gpm_pkg::GPM_NORMAL;
            else if (calib_done_i)
               state_d = gpm_pkg::GPM_SLEEP;
         gpm_pkg::GPM_SLEEP:
            if (hib_w)
               state_d = gpm_pkg::GPM_HIBERNATE;
            else if (high_i_w || wake_det_i)
               state_d = gpm_pkg::GPM_NORMAL;
         gpm_pkg::GPM_HIBERNATE:
            if (hit_w)
               state_d = gpm_pkg::GPM_INIT;
         default:
            state_d = gpm_pkg::GPM_INSERT_WAIT;
      endcase
      // Removal ends gauging from any powered state
      if (!bat_present_i && state_q != gpm_pkg::GPM_HIBERNATE)
         state_d = gpm_pkg::GPM_INSERT_WAIT;
   end

   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         state_q     <= gpm_pkg::GPM_INSERT_WAIT;
         init_cnt_q  <= 32'h0000_0000;
         good_q      <= 1'b0;
         ocv_valid_q <= 1'b0;
      end
      else
      begin
         state_q    <= state_d;
         init_cnt_q <= (state_d == gpm_pkg::GPM_INIT && state_q == state_d) ?
                       init_cnt_q + 32'h0000_0001 : 32'h0000_0000;
         if (state_d inside {gpm_pkg::GPM_HIBERNATE,
             gpm_pkg::GPM_INSERT_WAIT} || (state_d == gpm_pkg::GPM_INIT &&
             state_q != gpm_pkg::GPM_INIT))
         begin
            good_q      <= 1'b0;
            ocv_valid_q <= 1'b0;
         end
         else if (state_q == gpm_pkg::GPM_INIT && ocv_done_i)
         begin
            good_q      <= 1'b1;
            ocv_valid_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         battery_good_line_o <= 1'b1;
         charging_o          <= 1'b0;
         gauging_o           <= 1'b0;
         hfo_on_o            <= 1'b1;
         cpu_run_o           <= 1'b0;
         ocv_measure_o       <= 1'b0;
         profile_select_o    <= 1'b0;
         calib_start_o       <= 1'b0;
         temp_sample_o       <= 1'b0;
         power_mode_o        <= 3'h0;
         serve_q             <= 1'b0;
      end
      else
      begin
         battery_good_line_o <= (good_q & ~inhibit_q) ~^
                                rf_q[0][gpm_pkg::B_POL];
         charging_o    <= charging_q;
         gauging_o     <= gauge_w;
         hfo_on_o      <= !(state_q inside {gpm_pkg::GPM_SLEEP,
            gpm_pkg::GPM_HIBERNATE, gpm_pkg::GPM_INSERT_WAIT});
         // Halted insert wait still serves addressed commands
         if (state_q == gpm_pkg::GPM_INSERT_WAIT && hit_w)
            serve_q <= 1'b1;
         else if (stop_w || state_q != gpm_pkg::GPM_INSERT_WAIT)
            serve_q <= 1'b0;
         cpu_run_o     <= gauge_w || serve_q ||
                          state_q == gpm_pkg::GPM_INIT;
         ocv_measure_o <= state_d == gpm_pkg::GPM_INIT &&
                          state_q != gpm_pkg::GPM_INIT;
         profile_select_o <= state_q == gpm_pkg::GPM_INIT && ocv_done_i;
         calib_start_o <= state_d == gpm_pkg::GPM_CALIB &&
                          state_q != gpm_pkg::GPM_CALIB;
         // Codes 0 and 2 skip periodic samples while charging
         temp_sample_o <= (pfc1_w || !charging_q) ? meas_tick_i & gauge_w
            : rd_setup_w && (paddr_i == gpm_pkg::A_TEMP);
         power_mode_o  <= state_q;
      end
   end

   // Clock stretch while the sleeping core catches up
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         stretch_q <= 32'h0000_0000;
         scl_o     <= 1'b0;
         scl_oe_o  <= 1'b0;
      end
      else
      begin
         scl_o <= 1'b0;
         if (state_q == gpm_pkg::GPM_SLEEP && hit_w)
            stretch_q <= STRETCH_CYC;
         else if (stretch_q != 32'h0000_0000)
            stretch_q <= stretch_q - 32'h0000_0001;
         scl_oe_o <= stretch_q != 32'h0000_0000;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);

   sequence seq_calib_done;
      state_q == gpm_pkg::GPM_CALIB && calib_done_i && !high_i_w &&
      !wake_det_i && bat_present_i;
   endsequence

   AST_TERM_CLEAR: assert property (term_w |=> !charging_q)
      else $error("charging flag not cleared on termination");
   AST_COPY_CAP: assert property (term_w &&
      rf_q[0][gpm_pkg::B_COPY] |=> rf_q[13] == $past(rf_q[14]))
      else $error("remaining capacity not loaded");
   AST_INHIBIT_SET: assert property (pfc1_w && gauge_w &&
      meas_tick_i && temperature_i > $signed(rf_q[10]) |=> inhibit_q)
      else $error("inhibit not raised above high threshold");
   AST_SLEEP_AFTER_CAL: assert property (seq_calib_done
      |=> state_q == gpm_pkg::GPM_SLEEP)
      else $error("sleep not entered after calibration");
   AST_SLEEP_VIA_CAL: assert property ($rose(state_q ==
      gpm_pkg::GPM_SLEEP) |-> $past(state_q) == gpm_pkg::GPM_CALIB)
      else $error("sleep entered without calibration");
   AST_LIGHT_EXIT: assert property (state_q == gpm_pkg::GPM_LIGHT &&
      act_w && bat_present_i |=> state_q == gpm_pkg::GPM_NORMAL)
      else $error("light sleep kept despite traffic");
   AST_REMOVAL: assert property (gauge_w && !bat_present_i
      |=> state_q == gpm_pkg::GPM_INSERT_WAIT ##1 !gauging_o)
      else $error("gauging continued after removal");
   AST_HIB_HOLD: assert property (!hit_w &&
      state_q == gpm_pkg::GPM_HIBERNATE |=> state_q == gpm_pkg::GPM_HIBERNATE)
      else $error("hibernate left without addressed command");
   AST_HIB_LINE: assert property (state_q == gpm_pkg::GPM_HIBERNATE
      [*2] |-> battery_good_line_o != rf_q[0][gpm_pkg::B_POL])
      else $error("good line asserted in hibernate");
   AST_INIT_BOUND: assert property (init_cnt_q < INIT_CYC)
      else $error("initialization overran its time");
   AST_RESET_COUNT: assert property (sw_rst_w
      |=> reset_cnt_q == $past(reset_cnt_q) + 16'h0001)
      else $error("reset counter not incremented");
endmodule
`default_nettype wire

// >>> rtl/gpm_i2c_watch.sv
package gpm_pkg;
   localparam int unsigned CLK_HZ          = 50_000_000;
   localparam int unsigned INIT_TIME_S     = 2;
   localparam int unsigned INIT_CYC        = INIT_TIME_S * CLK_HZ;
   localparam int unsigned STRETCH_TIME_US = 4000;
   localparam int unsigned STRETCH_CYC     =
      STRETCH_TIME_US * (CLK_HZ / 1_000_000);
   localparam logic [15:0] TAPER_UAH       = 16'h00FA;
   localparam logic [7:0]  A_CFG  = 8'h00;
   localparam logic [7:0]  A_CTRL = 8'h04;
   localparam logic [7:0]  A_RES  = 8'h08;
   localparam logic [7:0]  A_CHGV = 8'h0C;
   localparam logic [7:0]  A_TAPI = 8'h10;
   localparam logic [7:0]  A_TAPV = 8'h14;
   localparam logic [7:0]  A_SLPI = 8'h18;
   localparam logic [7:0]  A_HIBI = 8'h1C;
   localparam logic [7:0]  A_HIBV = 8'h20;
   localparam logic [7:0]  A_TLO  = 8'h24;
   localparam logic [7:0]  A_THI  = 8'h28;
   localparam logic [7:0]  A_THYS = 8'h2C;
   localparam logic [7:0]  A_STAT = 8'h30;
   localparam logic [7:0]  A_RCAP = 8'h34;
   localparam logic [7:0]  A_FCAP = 8'h38;
   localparam logic [7:0]  A_TEMP = 8'h3C;
   localparam int unsigned B_FC_HI  = 12;
   localparam int unsigned B_FC_LO  = 11;
   localparam int unsigned B_HIBREQ = 9;
   localparam int unsigned B_LSLP   = 8;
   localparam int unsigned B_SLEEP  = 5;
   localparam int unsigned B_COPY   = 4;
   localparam int unsigned B_POL    = 2;
   localparam logic [15:0] RST_CFG  = 16'h0830;
   localparam logic [15:0] RST_CHGV = 16'h1068;
   localparam logic [15:0] RST_TAPI = 16'h0064;
   localparam logic [15:0] RST_TAPV = 16'h0064;
   localparam logic [15:0] RST_SLPI = 16'h000A;
   localparam logic [15:0] RST_HIBI = 16'h0008;
   localparam logic [15:0] RST_HIBV = 16'h0898;
   localparam logic [15:0] RST_TLO  = 16'h0000;
   localparam logic [15:0] RST_THI  = 16'h01C2;
   localparam logic [15:0] RST_THYS = 16'h0032;
   localparam logic [15:0] RST_RCAP = 16'h0000;
   localparam logic [15:0] RST_FCAP = 16'h0000;
   localparam logic [15:0] SUB_RESET      = 16'h0001;
   localparam logic [15:0] SUB_RESET_DATA = 16'h0002;
   localparam logic [6:0]  DEV_ADDR       = 7'h2A;
   typedef enum logic [2:0] {
      GPM_INSERT_WAIT, GPM_INIT, GPM_NORMAL, GPM_LIGHT,
      GPM_CALIB, GPM_SLEEP, GPM_HIBERNATE
   } gpm_state_t;
endpackage

`timescale 1ns/1ps
`default_nettype none
module gpm_i2c_watch #(
   parameter logic [6:0] ADDR = gpm_pkg::DEV_ADDR
) (
   input  wire logic clk_i,
   input  wire logic srst_i,
   input  wire logic scl_i,
   input  wire logic sda_i,
   output logic      act_o,
   output logic      hit_o,
   output logic      stop_o
);
   logic [1:0] scl_s_q;
   logic [1:0] sda_s_q;
   logic       scl_q;
   logic       sda_q;
   logic [3:0] bits_q;
   logic [7:0] shift_q;
   logic       in_addr_q;
   logic       start_w;
   logic       stop_w;
   logic       rise_w;

   // Pins are asynchronous to clk_i
   always_ff @(posedge clk_i)
   begin
      scl_s_q <= {scl_s_q[0], scl_i};
      sda_s_q <= {sda_s_q[0], sda_i};
      scl_q   <= scl_s_q[1];
      sda_q   <= sda_s_q[1];
   end

   assign start_w = scl_s_q[1] & scl_q & sda_q & ~sda_s_q[1];
   assign stop_w  = scl_s_q[1] & scl_q & ~sda_q & sda_s_q[1];
   assign rise_w  = scl_s_q[1] & ~scl_q;

   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         bits_q    <= 4'h0;
         shift_q   <= 8'h00;
         in_addr_q <= 1'b0;
         act_o     <= 1'b0;
         hit_o     <= 1'b0;
         stop_o    <= 1'b0;
      end
      else
      begin
         act_o  <= start_w;
         stop_o <= stop_w;
         hit_o  <= 1'b0;
         if (start_w)
         begin
            bits_q    <= 4'h0;
            in_addr_q <= 1'b1;
         end
         else if (stop_w)
            in_addr_q <= 1'b0;
         else if (in_addr_q && rise_w)
         begin
            shift_q <= {shift_q[6:0], scl_q ? sda_s_q[1] : sda_q};
            bits_q  <= bits_q + 4'h1;
            if (bits_q == 4'h7)
            begin
               in_addr_q <= 1'b0;
               // Direction bit arrives now; address is already in
               hit_o     <= (shift_q[6:0] == ADDR);
            end
         end
      end
   end
endmodule
`default_nettype wire

// >>> test/gpm_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module gpm_host_model (
   input  wire logic clk_i,
   input  wire logic scl_line_i,
   output logic      scl_o,
   output logic      sda_o
);
   // SCL stands high between frames; lines are pulled up
   initial
   begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   // Rising SCL waits for the device to let go
   task automatic rise();
      scl_o <= 1'b1;
      do @(posedge clk_i); while (scl_line_i !== 1'b1);
   endtask
   // START, address with write bit, STOP; 4 cycles a half bit
   task automatic frame(input logic [6:0] adr);
      logic [7:0] b;
      b = {adr, 1'b0};
      @(posedge clk_i) sda_o <= 1'b0;
      for (int i = 7; i >= 0; i--)
      begin
         repeat (4) @(posedge clk_i);
         scl_o <= 1'b0;
         repeat (2) @(posedge clk_i);
         sda_o <= b[i];
         repeat (2) @(posedge clk_i);
         rise();
      end
      repeat (4) @(posedge clk_i);
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      repeat (4) @(posedge clk_i);
      rise();
      repeat (4) @(posedge clk_i);
      sda_o <= 1'b1;
   endtask
endmodule
`default_nettype wire

// >>> test/gpm_power_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
module gpm_power_ctrl_test;
   logic clk_i, srst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
   logic [7:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, rd;
   logic [3:0] pstrb_i;
   logic h_scl, h_sda, scl_o, scl_oe_o, bat_present_i, meas_tick_i;
   logic taper_tick_i, wake_det_i, ocv_done_i, calib_done_i;
   logic signed [15:0] mean_current_i, temperature_i;
   logic [15:0] cell_voltage_i, cap_delta_i;
   logic battery_good_line_o, charging_o, gauging_o, hfo_on_o, cpu_run_o;
   logic ocv_measure_o, profile_select_o, calib_start_o, temp_sample_o;
   logic [2:0] power_mode_o;
   logic [7:0] cnt = 8'h00;
   logic err, seen_oe, seen_norm, seen_init;
   wire logic scl_i = h_scl & ~scl_oe_o;
   wire logic sda_i = h_sda;
   int failures = 0;
   int compares = 0;
   gpm_power_ctrl #(.INIT_CYC(200), .STRETCH_CYC(20)) i_gpm_power_ctrl (
      .clk_i, .srst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
      .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .scl_i, .sda_i, .scl_o,
      .scl_oe_o, .bat_present_i, .mean_current_i, .cell_voltage_i,
      .temperature_i, .cap_delta_i, .meas_tick_i, .taper_tick_i,
      .wake_det_i, .ocv_done_i, .calib_done_i, .battery_good_line_o,
      .charging_o, .gauging_o, .hfo_on_o, .cpu_run_o, .ocv_measure_o,
      .profile_select_o, .calib_start_o, .temp_sample_o, .power_mode_o);
   gpm_host_model i_gpm_host_model (.clk_i, .scl_line_i(scl_i),
      .scl_o(h_scl), .sda_o(h_sda));
   initial
   begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   // Measurement ticks, and the analog side answering its requests
   always @(posedge clk_i)
   begin
      cnt <= cnt + 8'h01;
      meas_tick_i <= (cnt[3:0] == 4'h0);
      taper_tick_i <= (cnt[5:0] == 6'h00);
      ocv_done_i <= ocv_measure_o;
      calib_done_i <= calib_start_o;
      if (scl_oe_o === 1'b1) seen_oe <= 1'b1;
      if (power_mode_o === 3'h2) seen_norm <= 1'b1;
      if (power_mode_o === 3'h1) seen_init <= 1'b1;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         failures++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i) penable_i <= 1'b1;
      do @(posedge clk_i); while (pready_o !== 1'b1 && ++n < 50);
      rd = prdata_o;
      err = pslverr_o;
      chk(32'(pready_o), 32'h1);
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic wait_mode(input logic [2:0] m);
      int n;
      n = 0;
      while (power_mode_o !== m && n++ < 3000) @(posedge clk_i);
      chk(32'(power_mode_o), 32'(m));
   endtask
   task automatic t_regs();
      apb(1'b0, gpm_pkg::A_CHGV, 32'h0);
      chk(rd, 32'h00001068);
      apb(1'b1, gpm_pkg::A_CTRL, 32'(gpm_pkg::SUB_RESET));
      apb(1'b1, gpm_pkg::A_CTRL, 32'(gpm_pkg::SUB_RESET));
      apb(1'b1, gpm_pkg::A_CTRL, 32'(gpm_pkg::SUB_RESET_DATA));
      apb(1'b0, gpm_pkg::A_RES, 32'h0);
      chk(rd, 32'h00000002);
      apb(1'b0, 8'h40, 32'h0);
      chk(32'(err), 32'h1);
      $display("test regs done");
   endtask
   task automatic t_insert();
      bat_present_i <= 1'b1;
      wait_mode(3'h1);
      wait_mode(3'h2);
      chk(32'(battery_good_line_o), 32'h0);
      chk(32'(gauging_o), 32'h1);
      $display("test insert done");
   endtask
   task automatic t_charge();
      apb(1'b1, gpm_pkg::A_FCAP, 32'h00001234);
      mean_current_i <= 16'sh00C8;
      repeat (4) @(posedge clk_i);
      chk(32'(charging_o), 32'h1);
      mean_current_i <= 16'sh0032;
      cap_delta_i <= 16'h0064;
      cell_voltage_i <= 16'h1036;
      repeat (200) @(posedge clk_i);
      chk(32'(charging_o), 32'h0);
      apb(1'b0, gpm_pkg::A_RCAP, 32'h0);
      chk(rd, 32'h00001234);
      cap_delta_i <= 16'h0000;
      $display("test charge done");
   endtask
   task automatic t_inhibit();
      temperature_i <= 16'sh01F4;
      repeat (40) @(posedge clk_i);
      chk(32'(battery_good_line_o), 32'h1);
      temperature_i <= 16'sh01A4;
      repeat (40) @(posedge clk_i);
      chk(32'(battery_good_line_o), 32'h1);
      temperature_i <= 16'sh00C8;
      repeat (40) @(posedge clk_i);
      chk(32'(battery_good_line_o), 32'h0);
      $display("test inhibit done");
   endtask
   task automatic t_sleep();
      mean_current_i <= 16'sh0000;
      wait_mode(3'h5);
      seen_oe <= 1'b0;
      i_gpm_host_model.frame(gpm_pkg::DEV_ADDR);
      chk(32'(seen_oe), 32'h1);
      mean_current_i <= 16'sh0032;
      wait_mode(3'h2);
      $display("test sleep done");
   endtask
   task automatic t_light();
      apb(1'b1, gpm_pkg::A_CFG, 32'h00000930);
      mean_current_i <= 16'sh0000;
      wait_mode(3'h3);
      chk(32'(hfo_on_o), 32'h1);
      seen_norm <= 1'b0;
      i_gpm_host_model.frame(7'h11);
      chk(32'(seen_norm), 32'h1);
      $display("test light done");
   endtask
   task automatic t_hib();
      mean_current_i <= 16'sh0032;
      cell_voltage_i <= 16'h07D0;
      wait_mode(3'h6);
      chk(32'(battery_good_line_o), 32'h1);
      cell_voltage_i <= 16'h0ED8;
      i_gpm_host_model.frame(7'h11);
      chk(32'(power_mode_o), 32'h6);
      seen_init <= 1'b0;
      i_gpm_host_model.frame(gpm_pkg::DEV_ADDR);
      chk(32'(seen_init), 32'h1);
      wait_mode(3'h2);
      bat_present_i <= 1'b0;
      wait_mode(3'h0);
      chk(32'(gauging_o), 32'h0);
      $display("test hibernate done");
   endtask
   task automatic end_of_test();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      {psel_i, penable_i, pwrite_i, bat_present_i, wake_det_i} = 5'h00;
      {paddr_i, pwdata_i, pstrb_i} = 44'h0;
      {meas_tick_i, taper_tick_i, ocv_done_i, calib_done_i} = 4'h0;
      {seen_oe, seen_norm, seen_init, srst_i} = 4'h1;
      mean_current_i = 16'sh0032;
      cell_voltage_i = 16'h0ED8;
      temperature_i = 16'sh00C8;
      cap_delta_i = 16'h0000;
      repeat (16) @(posedge clk_i);
      srst_i <= 1'b0;
      pstrb_i <= 4'hF;
      @(posedge clk_i);
      t_regs();
      t_insert();
      t_charge();
      t_inhibit();
      t_sleep();
      t_light();
      t_hib();
      end_of_test();
   end
   initial
   begin
      #400_000;
      failures++;
      end_of_test();
   end
endmodule
`default_nettype wire
